// ==== fcs_ctrl.sv ====
// Flash command, status and protection logic with register port.
// Assumes a same-clock register master, an outside array model that
// executes program/erase pulses, and a nonvolatile protect image input.
//
// How it works
// R01 - Key-window writes start commands when keys disabled
// R02 - Key-window writes become compare keys when enabled
// R03 - Protection loaded from image at reset only
// R04 - Debug writes may alter protection register
// R05 - Boundary field protects high flash block
// R06 - Disable bit zero unprotects all flash
// R07 - Writing one to buffer-empty launches command
// R08 - Only burst programs buffer; flag shows room
// R09 - Complete flag set when idle and empty
// R10 - Protected target ignored, violation flag set
// R11 - Sequence, divider or stop errors set access flag
// R12 - Blank check success sets blank flag
// R13 - Decode blank, byte and burst program
// R14 - Decode page erase and mass erase
// R15 - Unknown codes raise access error
// R16 - Program/erase blocked until divider written
// R17 - Blank pass or key match unsecures device
// R18 - Reset shows empty and complete set only
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_ctrl
  import fcs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_flash_wr,
  input wire logic dbg_prot_wr,
  input wire logic [7:0] dbg_prot_data,
  input wire logic [7:0] nv_protect_image,
  input wire logic [63:0] nonvolatile_unlock_key,
  input wire logic stop_req,
  input wire logic array_erased,
  output logic arr_go,
  output logic [7:0] arr_cmd,
  output logic [15:0] arr_addr,
  output logic [7:0] arr_data,
  output logic [63:0] key_compare,
  output logic irq
);
  fcs_state_s q;
  fcs_state_s d;
  logic [63:0] key_q;
  logic [2:0] key_idx_q;
  logic key_ok;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_known(input logic [7:0] c);
    is_known = (c == `FCS_CMD_BLANK) || (c == `FCS_CMD_BYTE) || // R13
      (c == `FCS_CMD_BURST) || (c == `FCS_CMD_PAGE) || // R13 R14
      (c == `FCS_CMD_MASS); // R14
  endfunction

  function automatic logic is_modify(input logic [7:0] c);
    is_modify = (c != `FCS_CMD_BLANK);
  endfunction

  // Protected when above boundary; mass erase touches the block too
  function automatic logic is_protected(input logic [7:0] p, input logic [15:0] a,
    input logic [7:0] c);
    logic [15:0] top;
    top = {p[7:1], {`FCS_PAGE_BITS{1'b1}}};
    if (p[`FCS_PROT_DIS]) // R06
      is_protected = 1'b0;
    else if (c == `FCS_CMD_MASS)
      is_protected = 1'b1;
    else if (c == `FCS_CMD_PAGE)
      is_protected = ({a[15:`FCS_PAGE_BITS], {`FCS_PAGE_BITS{1'b1}}} > top); // R05
    else
      is_protected = (a > top); // R05
  endfunction

  function automatic logic in_key(input logic [15:0] a);
    in_key = (a >= `FCS_KEY_BASE) && (a <= `FCS_KEY_LAST);
  endfunction

  // ---------------------------------------------------------------
  // Key capture
  // ---------------------------------------------------------------
  // Key bytes live outside the struct because they shift per byte
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      key_q <= 64'h0;
      key_idx_q <= 3'h0;
    end
    else if (cpu_flash_wr && in_key(cpu_addr) && q.cfg[`FCS_CFG_KEY_WRITE_ENABLE]) // R02
    begin
      key_q <= {key_q[55:0], cpu_wdata};
      key_idx_q <= key_idx_q + 3'h1;
    end
  end

  assign key_ok = (key_q == nonvolatile_unlock_key);
  assign key_compare = key_q;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic launch;
    logic fault;
    logic wr_status;
    launch = 1'b0;
    fault = 1'b0;
    wr_status = reg_wr && (reg_addr == `FCS_ADDR_STATUS);
    d = q;
    d.stop_s1 = stop_req;
    d.stop_s2 = q.stop_s1;
    d.arr_erased = array_erased;
    d.rdata = 8'h00;
    // Protection image taken on the first clock after reset release
    if (!q.loaded)
    begin
      d.prot = nv_protect_image; // R03
      d.loaded = 1'b1;
    end
    if (dbg_prot_wr)
      d.prot = dbg_prot_data; // R04
    if (reg_wr)
    begin
      case (reg_addr)
        `FCS_ADDR_CONFIG: d.cfg = reg_wdata & 8'h20;
        `FCS_ADDR_COMMAND:
        begin
          d.cmd = reg_wdata;
          if (q.st != FCS_ARMED)
            fault = 1'b1; // R11
        end
        `FCS_ADDR_DIVIDER:
        begin
          d.div = reg_wdata;
          d.divider_loaded_flag = 1'b1; // R16
        end
        `FCS_ADDR_IRQ_STATUS: d.irq_st = q.irq_st & ~reg_wdata[2:0];
        `FCS_ADDR_IRQ_MASK: d.irq_mask = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (wr_status)
    begin
      if (reg_wdata[`FCS_ST_PVIOL])
        d.pviol = 1'b0; // R10
      if (reg_wdata[`FCS_ST_ACCERR])
        d.accerr = 1'b0; // R11
    end
    // Array write in key window (keys off) or anywhere outside it arms a command
    if (cpu_flash_wr && !(in_key(cpu_addr) && q.cfg[`FCS_CFG_KEY_WRITE_ENABLE])) // R01
    begin
      if (q.cbef && q.st != FCS_ARMED)
      begin
        d.st = FCS_ARMED;
        d.addr = cpu_addr;
        d.data = cpu_wdata;
      end
      else if (!q.cbef)
        fault = 1'b1; // R11
    end
    if (wr_status && reg_wdata[`FCS_ST_CBEF] && q.cbef) // R07
    begin
      if (q.st != FCS_ARMED)
        fault = 1'b1; // R11
      else if (!is_known(q.cmd))
        fault = 1'b1; // R15
      else if (is_modify(q.cmd) && !q.divider_loaded_flag)
        fault = 1'b1; // R16
      else if (is_modify(q.cmd) && is_protected(q.prot, q.addr, q.cmd))
      begin
        d.pviol = 1'b1; // R10
        d.irq_st[`FCS_EV_PVIOL] = 1'b1;
        d.st = (q.timer != 8'h00) ? FCS_BUSY : FCS_IDLE;
      end
      // Only a burst may queue behind a running burst
      else if (q.timer != 8'h00 && !(q.cmd == `FCS_CMD_BURST && q.cur_cmd == `FCS_CMD_BURST))
        fault = 1'b1; // R08
      else
        launch = 1'b1;
    end
    // Array in progress
    if (q.timer != 8'h00)
    begin
      d.timer = q.timer - 8'h01;
      if (q.timer == 8'h01)
      begin
        if (q.cur_cmd == `FCS_CMD_BLANK && q.arr_erased)
        begin
          d.blank = 1'b1; // R12
          d.sec = `FCS_UNSECURE; // R17
        end
        d.cbef = 1'b1; // R08
        if (q.buf_full)
        begin
          // Buffered burst byte goes to the array now
          d.buf_full = 1'b0;
          d.addr = q.buf_addr;
          d.data = q.buf_data;
          d.timer = `FCS_OP_CYCLES;
        end
      end
    end
    // Burst frees the buffer once the array has taken it
    if (q.timer == `FCS_OP_CYCLES && q.cur_cmd == `FCS_CMD_BURST)
      d.cbef = 1'b1; // R08
    // Applied after the timer so a launch on the last busy cycle is not lost
    if (launch)
    begin
      d.cbef = 1'b0; // R07
      d.blank = 1'b0; // R12
      d.st = FCS_BUSY;
      if (q.timer <= 8'h01)
      begin
        d.cur_cmd = q.cmd;
        d.timer = `FCS_OP_CYCLES;
      end
      else
      begin
        d.buf_full = 1'b1; // R08
        d.buf_addr = q.addr;
        d.buf_data = q.data;
      end
    end
    if (q.st == FCS_BUSY && q.timer == 8'h00 && !q.buf_full && !launch)
      d.st = FCS_IDLE;
    if (key_ok && key_idx_q == 3'h0 && q.cfg[`FCS_CFG_KEY_WRITE_ENABLE])
      d.sec = `FCS_UNSECURE; // R17
    // Stop during a command aborts it
    if (q.stop_s2 && q.timer != 8'h00)
    begin
      fault = 1'b1; // R11
      d.timer = 8'h00;
      d.buf_full = 1'b0;
      d.cbef = 1'b1;
    end
    if (fault)
    begin
      d.accerr = 1'b1; // R11
      d.irq_st[`FCS_EV_ACCERR] = 1'b1;
      d.st = (q.timer != 8'h00) ? FCS_BUSY : FCS_IDLE;
    end
    if (q.timer == 8'h01 && !q.buf_full)
      d.irq_st[`FCS_EV_DONE] = 1'b1;
    if (reg_rd)
    begin
      case (reg_addr)
        `FCS_ADDR_CONFIG: d.rdata = q.cfg;
        `FCS_ADDR_PROTECT: d.rdata = q.prot; // R03
        `FCS_ADDR_STATUS: d.rdata = {q.cbef, (q.cbef && q.timer == 8'h00 && // R09
          q.st != FCS_ARMED), q.pviol, q.accerr, 1'b0, q.blank, 2'b00};
        `FCS_ADDR_COMMAND: d.rdata = q.cmd;
        `FCS_ADDR_DIVIDER: d.rdata = {q.divider_loaded_flag, q.div[6:0]};
        `FCS_ADDR_SECURITY: d.rdata = {6'h00, q.sec};
        `FCS_ADDR_IRQ_STATUS: d.rdata = {5'h00, q.irq_st};
        `FCS_ADDR_IRQ_MASK: d.rdata = {5'h00, q.irq_mask};
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.cbef <= 1'b1; // R18
      q.st <= FCS_IDLE;
    end
    else
      q <= d;
  end

  assign reg_rdata = q.rdata;
  assign arr_go = (q.timer == `FCS_OP_CYCLES);
  assign arr_cmd = q.cur_cmd;
  assign arr_addr = q.addr;
  assign arr_data = q.data;
  assign irq = |(q.irq_st & q.irq_mask);
endmodule // fcs_ctrl

// ==== fcs_params.svh ====
// Constants for the flash command and status block.
// Assumes inclusion by the design module only.
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
// Register indices on the plain register port
`define FCS_ADDR_CONFIG 4'h0
`define FCS_ADDR_PROTECT 4'h1
`define FCS_ADDR_STATUS 4'h2
`define FCS_ADDR_COMMAND 4'h3
`define FCS_ADDR_DIVIDER 4'h4
`define FCS_ADDR_SECURITY 4'h5
`define FCS_ADDR_IRQ_STATUS 4'h6
`define FCS_ADDR_IRQ_MASK 4'h7
// Status bit positions
`define FCS_ST_CBEF 7
`define FCS_ST_CCF 6
`define FCS_ST_PVIOL 5
`define FCS_ST_ACCERR 4
`define FCS_ST_BLANK 2
// Config bit position
`define FCS_CFG_KEY_WRITE_ENABLE 5
// Protection fields
`define FCS_PROT_DIS 0
// Command codes
`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_BYTE 8'h20
`define FCS_CMD_BURST 8'h25
`define FCS_CMD_PAGE 8'h40
`define FCS_CMD_MASS 8'h41
// Key window, page size, unsecure security code
`define FCS_KEY_BASE 16'hFFB0
`define FCS_KEY_LAST 16'hFFB7
`define FCS_PAGE_BITS 9
`define FCS_UNSECURE 2'h2
// Interrupt event bits: 0 complete, 1 violation, 2 access error
`define FCS_EV_DONE 0
`define FCS_EV_PVIOL 1
`define FCS_EV_ACCERR 2
// Fixed array operation time in cycles (stand-in for the timed pulses)
`define FCS_OP_CYCLES 8'h10
`endif

// ==== fcs_pkg.sv ====
// Types for the flash command and status block.
// Assumes fcs_params.svh is on the include path.
package fcs_pkg;
  typedef enum logic [1:0]
  {
    FCS_IDLE = 2'b00,
    FCS_ARMED = 2'b01,
    FCS_BUSY = 2'b10
  } fcs_state_e;

  typedef struct packed
  {
    fcs_state_e st;
    logic [7:0] cfg;
    logic [7:0] prot;
    logic [7:0] cmd;
    logic [7:0] cur_cmd;
    logic [15:0] addr;
    logic [7:0] data;
    logic buf_full;
    logic [15:0] buf_addr;
    logic [7:0] buf_data;
    logic cbef;
    logic pviol;
    logic accerr;
    logic blank;
    logic divider_loaded_flag;
    logic [7:0] div;
    logic [1:0] sec;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    logic [7:0] timer;
    logic loaded;
    logic stop_s1;
    logic stop_s2;
    logic arr_erased;
  } fcs_state_s;
endpackage

// ==== fcs_array_model.sv ====
// Flash array stand-in that reports the erased level.
// Assumes one arr_go pulse per operation.
`timescale 1ns/1ps
module fcs_array_model
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic arr_go,
  input wire logic [7:0] arr_cmd,
  input wire logic [3:0] lag,
  output logic array_erased
);
  // ----
  // Array state
  // ----
  // F means dirty; lag below F lets the bench answer fast or slow
  logic [3:0] cnt_q;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= 4'hF;
    else if (arr_go && arr_cmd == 8'h41)
      cnt_q <= lag;
    else if (arr_go && arr_cmd[7:5] == 3'h1)
      cnt_q <= 4'hF;
    else if (cnt_q != 4'hF && cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
  assign array_erased = cnt_q == 4'h0;
endmodule // fcs_array_model

// ==== fcs_ctrl_properties.sv ====
// Port assertions for fcs_ctrl.
// Assumes one clock; bound from this file.
`timescale 1ns/1ps
module fcs_ctrl_properties
  import fcs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic dbg_prot_wr,
  input wire logic [7:0] dbg_prot_data,
  input wire logic arr_go,
  input wire logic [7:0] arr_cmd,
  input wire logic irq
);
  // ----
  // Checks
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic div_q;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      div_q <= 1'b0;
    else if (reg_wr && reg_addr == 4'h4)
      div_q <= 1'b1;
  end
  sequence prot_rd;
    reg_rd && reg_addr == 4'h1 && !dbg_prot_wr;
  endsequence
  sequence bad_launch;
    reg_wr && reg_addr == 4'h3 && !(reg_wdata inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
      ##1 reg_wr && reg_addr == 4'h2 && reg_wdata[7];
  endsequence
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  a_irq_reset: assert property (!$past(rstn) |-> !irq)
    else $error("irq after reset");
  a_prot_ignore: assert property (
    prot_rd ##1 (reg_wr && reg_addr == 4'h1 && !dbg_prot_wr) ##1 prot_rd
      |=> reg_rdata == $past(reg_rdata, 2)) else $error("protect written");
  a_dbg_write: assert property (dbg_prot_wr ##1 prot_rd |=>
    reg_rdata == $past(dbg_prot_data, 2)) else $error("debug write lost");
  a_bad_code: assert property (bad_launch |=> !arr_go [*6])
    else $error("illegal code ran");
  a_go_legal: assert property (arr_go |->
    arr_cmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("unknown op");
  a_go_spacing: assert property (arr_go |=> !arr_go [*8])
    else $error("ops too close");
  a_go_divider: assert property (arr_go && arr_cmd != 8'h05 |-> div_q)
    else $error("op before divider");
endmodule // fcs_ctrl_properties
bind fcs_ctrl fcs_ctrl_properties u_props (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .dbg_prot_wr, .dbg_prot_data, .arr_go, .arr_cmd, .irq);

// ==== fcs_ctrl_tb.sv ====
// Bench for fcs_ctrl with queued read checks.
// Assumes the array model and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module fcs_ctrl_tb;
  // ----
  // Stimulus and checks
  // ----
  logic clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cpu_flash_wr = 1'b0;
  logic dbg_prot_wr = 1'b0, stop_req = 1'b0, rd_pend = 1'b0, array_erased, arr_go, irq;
  logic [3:0] reg_addr = 4'h0, lag = 4'h0;
  logic [7:0] reg_wdata = 8'h00, cpu_wdata = 8'h00, dbg_prot_data = 8'h00, reg_rdata, m, e;
  logic [7:0] arr_cmd, arr_data, exp_q[$], msk_q[$], nv_protect_image = 8'hF0;
  logic [15:0] cpu_addr = 16'h0000, arr_addr, exp_addr = 16'h0000;
  logic [7:0] exp_data = 8'h00;
  logic [63:0] nonvolatile_unlock_key = 64'h0, key_compare;
  logic [7:0] bad_t[3] = '{8'h00, 8'h21, 8'hFF};
  logic [7:0] cmd_t[8] = '{8'h20, 8'h05, 8'h41, 8'h20, 8'h20, 8'h41, 8'h05, 8'h40};
  logic [7:0] sts_t[8] = '{8'hC0, 8'hC0, 8'hE0, 8'hE0, 8'hC0, 8'hC0, 8'hC4, 8'hC0};
  logic [15:0] adr_t[8] = '{16'h8000, 16'h8000, 16'h8000, 16'hF000, 16'hFFB2, 16'h8000,
    16'h8000, 16'h8200};
  int num_errors = 0, check_count = 0;
  always #10 clock = ~clock;
  fcs_ctrl u_dut (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_addr, .cpu_wdata, .cpu_flash_wr, .dbg_prot_wr, .dbg_prot_data, .nv_protect_image,
    .nonvolatile_unlock_key, .stop_req, .array_erased, .arr_go, .arr_cmd, .arr_addr,
    .arr_data, .key_compare, .irq);
  fcs_array_model u_arr (.clock, .rstn, .arr_go, .arr_cmd, .lag, .array_erased);
  always @(posedge clock) rd_pend <= reg_rd;
  always @(negedge clock)
  begin
    if (rd_pend)
    begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(reg_rdata & m, e)
    end
    if (arr_go)
    begin
      `CHK(arr_addr, exp_addr)
      `CHK(arr_data, exp_data)
    end
  end
  // Kinds: 0 idle, 1 reg write, 2 reg read, 3 flash write, 4 debug write
  task automatic drv(input int k, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= k == 1;
    reg_rd <= k == 2;
    cpu_flash_wr <= k == 3;
    dbg_prot_wr <= k == 4;
    reg_addr <= a[3:0];
    reg_wdata <= d;
    cpu_addr <= a;
    cpu_wdata <= d;
    dbg_prot_data <= d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x, input logic [7:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    drv(2, {12'h000, a}, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) drv(0, 16'h0000, 8'h00);
  endtask
  task automatic launch(input logic [7:0] c, input logic [15:0] a, input int n);
    logic [7:0] v;
    v = 8'($urandom);
    exp_addr = a;
    exp_data = v;
    lag <= 4'($urandom_range(7, 0));
    drv(3, a, v);
    drv(1, 16'h0003, c);
    drv(1, 16'h0002, 8'h80);
    idle(n);
  endtask
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test;
  end
  initial
  begin
    void'($urandom(32'h2176fc02));
    nonvolatile_unlock_key = {$urandom, $urandom};
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    idle(2);
    rd(4'h2, 8'hC0, 8'hF4);
    rd(4'h1, 8'hF0, 8'hFF);
    drv(1, 16'h0001, 8'h55);
    rd(4'h1, 8'hF0, 8'hFF);
    drv(4, 16'h0000, 8'hE0);
    rd(4'h1, 8'hE0, 8'hFF);
    drv(1, 16'h0007, 8'h04);
    launch(8'h20, 16'h8000, 24);
    rd(4'h2, 8'h10, 8'h10);
    idle(2);
    #1 `CHK(irq, 1'b1)
    drv(1, 16'h0002, 8'h10);
    drv(1, 16'h0006, 8'h07);
    rd(4'h2, 8'hC0, 8'hF4);
    idle(2);
    #1 `CHK(irq, 1'b0)
    drv(1, 16'h0004, 8'h13);
    rd(4'h4, 8'h80, 8'h80);
    foreach (bad_t[i])
    begin
      launch(bad_t[i], 16'h8000, 6);
      rd(4'h2, 8'h10, 8'h10);
      drv(1, 16'h0002, 8'h10);
    end
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4)
      begin
        drv(4, 16'h0000, 8'h01);
        rd(4'h1, 8'h01, 8'hFF);
      end
      launch(cmd_t[i], adr_t[i], 24);
      rd(4'h2, sts_t[i], 8'hF4);
      drv(1, 16'h0002, 8'h30);
    end
    rd(4'h5, 8'h02, 8'h03);
    launch(8'h25, 16'h8000, 2);
    rd(4'h2, 8'h00, 8'h40);
    launch(8'h25, 16'h8001, 1);
    rd(4'h2, 8'h00, 8'h80);
    idle(40);
    rd(4'h2, 8'hC0, 8'hF4);
    drv(1, 16'h0000, 8'h20);
    for (int i = 0; i < 8; i++)
      drv(3, 16'(16'hFFB0 + i), nonvolatile_unlock_key[63 - 8 * i -: 8]);
    idle(3);
    #1 `CHK(key_compare, nonvolatile_unlock_key)
    drv(1, 16'h0000, 8'h00);
    launch(8'h40, 16'h8400, 2);
    stop_req <= 1'b1;
    idle(6);
    stop_req <= 1'b0;
    idle(24);
    rd(4'h2, 8'h10, 8'h10);
    drv(1, 16'h0002, 8'h10);
    rd(4'hF, 8'h00, 8'hFF);
    idle(3);
    stop_test;
  end
endmodule // fcs_ctrl_tb
